// ===== core/dss_regs.svh
// Constants of the serial setup-command link: fields, codes and timing.
//
// How it works
// - Channel bits 3..0 select channels D..A.
// - Device ignores address and bits 15..4.
// - Host frame-sync, data, clock drive device pins.
// - Host serial port uses polarity 0, phase 1.
// - Data valid at falling clock edge; sampled there.
// - Frame select low before first, high after last.
// - Byte hosts hold frame select low between bytes.
// - Frame bits travel most significant bit first.
// - LSB-first hosts reverse bits before sending.
// - Three-wire host changes data on falling edge; this host does so one cycle after it, only with CHANGE_ON_FALL.
// - Frame valid after 24 falling edges, acts then.
// - Code 110 auto-update setup, 111 reference setup.
// - Auto-update bit high copies input to output.
// - Reference off at reset; bit 0 switches it.
`ifndef DSS_REGS_SVH
`define DSS_REGS_SVH

// ----------------------------------------------------------------
// Frame layout
// ----------------------------------------------------------------
`define DSS_FRAME_BITS 24
`define DSS_BYTE_BITS 8
`define DSS_CMD_MSB 21
`define DSS_CMD_LSB 19
`define DSS_CHAN_MSB 3
`define DSS_CHAN_LSB 0
`define DSS_REF_BIT 0

// ----------------------------------------------------------------
// Command codes and reset values
// ----------------------------------------------------------------
`define DSS_CMD_AUTO_UPD 3'h6
`define DSS_CMD_REF_SET 3'h7
`define DSS_REF_RST 1'h0
`define DSS_AUTO_RST 4'h0

// ----------------------------------------------------------------
// Timing: half serial clock period, least time, rounded up
// ----------------------------------------------------------------
`define DSS_REF_CLK_NS 100
`define DSS_SCLK_HALF_NS 400
`define DSS_SCLK_HALF_CYC \
  ((`DSS_SCLK_HALF_NS + `DSS_REF_CLK_NS - 1) / `DSS_REF_CLK_NS)

`endif

// ===== core/dss_pkg.sv
// Types of the host end of the serial setup-command link, also used by the bench.
package dss_pkg;

  // Host sequencer states.
  typedef enum logic [2:0] {
    HS_IDLE,
    HS_LEAD,
    HS_HIGH,
    HS_LOW,
    HS_GAP,
    HS_TAIL,
    HS_REST
  } dss_hst_e;

  typedef logic [23:0] dss_word_t;

endpackage

// ===== core/dss_if.sv
// Three-wire link between the host end and the converter end.
interface dss_if;
  logic frame_sel_n;
  logic sclk;
  logic sdin;

  // The host drives all three lines; the device only listens.
  modport host (output frame_sel_n, output sclk, output sdin);
  modport dev (input frame_sel_n, input sclk, input sdin);
endinterface

// ===== core/dss_device.sv
// Converter end: receives frames and runs the two setup commands.
`include "dss_regs.svh"

module dss_device #(
  parameter int DATA_W = 16
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  dss_if.dev link,
  input wire logic [DATA_W-1:0] chan_input_word [4],
  output logic [DATA_W-1:0] chan_output_word [4],
  output logic [3:0] output_load_control,
  output logic reference_enable,
  output logic frame_done
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  // Bit 2 frame select, bit 1 clock, bit 0 data.
  logic [2:0] sy1_ff;
  logic [2:0] sy2_ff;
  logic [2:0] sy3_ff;
  logic [2:0] stb_ff;
  logic [2:0] nxt_stb;

  // Three stages; only stages two and three are compared.
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      sy1_ff <= 3'h4;
      sy2_ff <= 3'h4;
      sy3_ff <= 3'h4;
    end else begin
      sy1_ff <= {link.frame_sel_n, link.sclk, link.sdin};
      sy2_ff <= sy1_ff;
      sy3_ff <= sy2_ff;
    end
  end

  // A line counts as changed once stages two and three agree.
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      nxt_stb[i] = (sy2_ff[i] == sy3_ff[i]) ? sy3_ff[i] : stb_ff[i];
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      stb_ff <= 3'h4;
    end else begin
      stb_ff <= nxt_stb;
    end
  end

  // ----------------------------------------------------------------
  // Frame shifter and command decode
  // ----------------------------------------------------------------
  logic [23:0] shift_ff;
  logic [23:0] nxt_shift;
  logic [4:0] cnt_ff;
  logic [4:0] nxt_cnt;
  logic [3:0] auto_ff;
  logic [3:0] nxt_auto;
  logic ref_ff;
  logic nxt_ref;
  logic done_ff;
  logic nxt_done;
  logic [DATA_W-1:0] out_ff [4];
  logic [DATA_W-1:0] nxt_out [4];
  logic fall;
  logic [23:0] word;
  logic [2:0] cmd;
  logic word_used_ff;
  logic nxt_used;

  assign fall = stb_ff[1] && !nxt_stb[1];
  // All 24 bits are held in the shifter, so the decode does not depend
  // on the data line still carrying the last bit after the final fall.
  assign word = shift_ff;
  assign cmd = word[`DSS_CMD_MSB:`DSS_CMD_LSB];

  // Extra edges after the 24th are ignored until frame select rises,
  // so a long frame cannot execute twice.
  always_comb begin
    nxt_shift = shift_ff;
    nxt_cnt = cnt_ff;
    nxt_auto = auto_ff;
    nxt_ref = ref_ff;
    nxt_done = 1'b0;
    nxt_out = out_ff;
    if (stb_ff[2]) begin
      nxt_cnt = 5'h00;
    end else if (fall && cnt_ff < 5'(`DSS_FRAME_BITS)) begin
      nxt_shift = {shift_ff[22:0], nxt_stb[0]};
      nxt_cnt = cnt_ff + 5'h01;
    end
    // The word completes one cycle after the 24th edge is seen.
    if (!stb_ff[2] && cnt_ff == 5'(`DSS_FRAME_BITS) && !word_used_ff)
    begin
      nxt_done = 1'b1;
      for (int c = 0; c < 4; c++) begin
        if (auto_ff[c]) begin
          nxt_out[c] = chan_input_word[c];
        end
      end
      // Address field and bits 15..4 take no part in decode.
      if (cmd == `DSS_CMD_AUTO_UPD) begin
        nxt_auto = word[`DSS_CHAN_MSB:`DSS_CHAN_LSB];
      end else if (cmd == `DSS_CMD_REF_SET) begin
        nxt_ref = word[`DSS_REF_BIT];
      end
    end
  end

  assign nxt_used = stb_ff[2] ? 1'b0 :
    (word_used_ff || cnt_ff == 5'(`DSS_FRAME_BITS));

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      shift_ff <= '0;
      cnt_ff <= 5'h00;
      auto_ff <= `DSS_AUTO_RST;
      ref_ff <= `DSS_REF_RST;
      done_ff <= 1'b0;
      word_used_ff <= 1'b0;
      for (int c = 0; c < 4; c++) begin
        out_ff[c] <= '0;
      end
    end else begin
      shift_ff <= nxt_shift;
      cnt_ff <= nxt_cnt;
      auto_ff <= nxt_auto;
      ref_ff <= nxt_ref;
      done_ff <= nxt_done;
      word_used_ff <= nxt_used;
      out_ff <= nxt_out;
    end
  end

  assign chan_output_word = out_ff;
  assign output_load_control = auto_ff;
  assign reference_enable = ref_ff;
  assign frame_done = done_ff;

endmodule

// ===== core/dss_host.sv
// Host end: sends 24-bit command frames over the three-wire link.
`include "dss_regs.svh"

module dss_host #(
  parameter int HALF_CYC = `DSS_SCLK_HALF_CYC,
  parameter bit BYTE_MODE = 1'b0,
  parameter int GAP_HALVES = 2,
  parameter bit LSB_NATIVE = 1'b0,
  parameter bit CHANGE_ON_FALL = 1'b0
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire dss_pkg::dss_word_t cmd_word,
  output logic busy,
  output logic frame_done,
  dss_if.host link
);

  // ----------------------------------------------------------------
  // Half-period divider
  // ----------------------------------------------------------------
  // The host makes the link clock, so it is a divided enable here and
  // not a second clock domain.
  logic [7:0] div_ff;
  logic [7:0] nxt_div;
  logic tick;

  assign tick = (div_ff == 8'(HALF_CYC - 1));

  // ----------------------------------------------------------------
  // Sequencer state
  // ----------------------------------------------------------------
  dss_pkg::dss_hst_e st_ff;
  dss_pkg::dss_hst_e nxt_st;
  dss_pkg::dss_word_t sh_ff;
  dss_pkg::dss_word_t nxt_sh;
  logic [4:0] bit_ff;
  logic [4:0] nxt_bit;
  logic [3:0] gap_ff;
  logic [3:0] nxt_gap;
  logic fs_n_ff;
  logic nxt_fs_n;
  logic sclk_ff;
  logic nxt_sclk;
  logic sdin_ff;
  logic nxt_sdin;
  logic pend_ff;
  logic nxt_pend;
  logic done_ff;
  logic nxt_done;

  // Bit reversal stands in for the software step of an LSB-first
  // port, so the wire still carries the MSB first.
  function automatic dss_pkg::dss_word_t rev(input dss_pkg::dss_word_t w);
    dss_pkg::dss_word_t r;
    r = '0;
    for (int i = 0; i < 24; i++) begin
      r[i] = w[23 - i];
    end
    return r;
  endfunction

  // Bit that goes on the wire next, from the held word.
  function automatic logic head(input dss_pkg::dss_word_t w);
    return LSB_NATIVE ? w[0] : w[23];
  endfunction

  function automatic dss_pkg::dss_word_t adv(input dss_pkg::dss_word_t w);
    return LSB_NATIVE ? {1'b0, w[23:1]} : {w[22:0], 1'b0};
  endfunction

  assign cmd_ready = (st_ff == dss_pkg::HS_IDLE);

  // Next-state logic for the frame sequencer.
  always_comb begin
    nxt_st = st_ff;
    nxt_sh = sh_ff;
    nxt_bit = bit_ff;
    nxt_gap = gap_ff;
    nxt_fs_n = fs_n_ff;
    nxt_sclk = sclk_ff;
    nxt_sdin = sdin_ff;
    nxt_pend = 1'b0;
    nxt_done = 1'b0;
    nxt_div = 8'h00;
    if (st_ff != dss_pkg::HS_IDLE && !tick) begin
      nxt_div = div_ff + 8'h01;
    end
    // Falling-edge mode changes data one cycle after the edge, so the
    // device has already sampled the old bit.
    if (pend_ff) begin
      nxt_sdin = head(sh_ff);
    end
    unique case (st_ff)
      dss_pkg::HS_IDLE: begin
        nxt_fs_n = 1'b1;
        nxt_sclk = 1'b0;
        if (cmd_valid) begin
          nxt_sh = LSB_NATIVE ? rev(cmd_word) : cmd_word;
          nxt_sdin = head(LSB_NATIVE ? rev(cmd_word) : cmd_word);
          nxt_fs_n = 1'b0;
          nxt_bit = 5'h00;
          nxt_st = dss_pkg::HS_LEAD;
        end
      end
      dss_pkg::HS_LEAD: begin
        if (tick) begin
          nxt_sclk = 1'b1;
          nxt_st = dss_pkg::HS_HIGH;
        end
      end
      dss_pkg::HS_HIGH: begin
        if (tick) begin
          nxt_sclk = 1'b0;
          nxt_sh = adv(sh_ff);
          nxt_bit = bit_ff + 5'h01;
          nxt_pend = CHANGE_ON_FALL;
          if (bit_ff == 5'(`DSS_FRAME_BITS - 1)) begin
            nxt_st = dss_pkg::HS_TAIL;
          end else if (BYTE_MODE &&
              bit_ff[2:0] == 3'(`DSS_BYTE_BITS - 1)) begin
            nxt_gap = 4'h0;
            nxt_st = dss_pkg::HS_GAP;
          end else begin
            nxt_st = dss_pkg::HS_LOW;
          end
        end
      end
      dss_pkg::HS_GAP: begin
        // Frame select stays low across the pause between bytes.
        if (tick) begin
          nxt_gap = gap_ff + 4'h1;
          if (gap_ff == 4'(GAP_HALVES - 1)) begin
            nxt_st = dss_pkg::HS_LOW;
          end
        end
      end
      dss_pkg::HS_LOW: begin
        if (tick) begin
          nxt_sclk = 1'b1;
          if (!CHANGE_ON_FALL) begin
            nxt_sdin = head(sh_ff);
          end
          nxt_st = dss_pkg::HS_HIGH;
        end
      end
      dss_pkg::HS_TAIL: begin
        // Frame select rises only after the last falling edge.
        if (tick) begin
          nxt_fs_n = 1'b1;
          nxt_st = dss_pkg::HS_REST;
        end
      end
      dss_pkg::HS_REST: begin
        if (tick) begin
          nxt_done = 1'b1;
          nxt_st = dss_pkg::HS_IDLE;
        end
      end
    endcase
  end

  // State registers of the sequencer and its pins.
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_ff <= dss_pkg::HS_IDLE;
      sh_ff <= '0;
      bit_ff <= 5'h00;
      gap_ff <= 4'h0;
      div_ff <= 8'h00;
      fs_n_ff <= 1'b1;
      sclk_ff <= 1'b0;
      sdin_ff <= 1'b0;
      pend_ff <= 1'b0;
      done_ff <= 1'b0;
    end else begin
      st_ff <= nxt_st;
      sh_ff <= nxt_sh;
      bit_ff <= nxt_bit;
      gap_ff <= nxt_gap;
      div_ff <= nxt_div;
      fs_n_ff <= nxt_fs_n;
      sclk_ff <= nxt_sclk;
      sdin_ff <= nxt_sdin;
      pend_ff <= nxt_pend;
      done_ff <= nxt_done;
    end
  end

  // Frame sync, data and clock drive the device lines directly.
  assign link.frame_sel_n = fs_n_ff;
  assign link.sclk = sclk_ff;
  assign link.sdin = sdin_ff;
  assign busy = (st_ff != dss_pkg::HS_IDLE);
  assign frame_done = done_ff;

endmodule

// ===== testbench/dss_link_chk.sv
// Checker of the three-wire link between the host and converter ends.
module dss_link_chk (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic frame_sel_n,
  input wire logic sclk,
  input wire logic sdin
);
  logic sclk_ff;
  logic nxt_sclk;
  logic [4:0] falls_ff;
  logic [4:0] nxt_falls;
  logic fall;

  // Falls are counted per frame; the count clears while the link idles.
  always_comb begin
    fall = sclk_ff & ~sclk;
    nxt_sclk = sclk;
    nxt_falls = frame_sel_n ? 5'h00 : falls_ff + {4'h0, fall};
  end

  // Plain registers, so the count is known right after reset.
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      sclk_ff <= 1'b0;
      falls_ff <= 5'h00;
    end else begin
      sclk_ff <= nxt_sclk;
      falls_ff <= nxt_falls;
    end
  end

  // ----
  // Properties
  // ----
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  sequence s_last_fall;
    fall && falls_ff == 5'h17;
  endsequence
  sequence s_tail;
    !frame_sel_n [*4] ##1 frame_sel_n;
  endsequence

  a_idle_clk_low: assert property (frame_sel_n |-> !sclk)
    else $error("serial clock high outside a frame");
  a_data_stable: assert property (fall |-> $stable(sdin))
    else $error("data moved at the sampling edge");
  a_lead_half: assert property (
    $fell(frame_sel_n) |-> !sclk [*4] ##1 sclk)
    else $error("first clock edge too early or late");
  a_full_frame: assert property (
    $rose(frame_sel_n) |-> falls_ff == 5'h18)
    else $error("frame closed without 24 falls");
  a_no_extra: assert property (fall |-> falls_ff < 5'h18)
    else $error("fall past the end of the frame");
  a_tail_wait: assert property (s_last_fall |-> s_tail)
    else $error("frame select not raised after last bit");
  a_high_half: assert property (
    $rose(sclk) |-> sclk [*4] ##1 !sclk)
    else $error("clock high time wrong");
  a_data_on_rise: assert property (
    !frame_sel_n && !$past(frame_sel_n) && falls_ff < 5'h18 &&
    $changed(sdin) |-> $rose(sclk))
    else $error("data changed off the rising edge");
  a_frame_gap: assert property (
    $rose(frame_sel_n) |-> frame_sel_n [*4])
    else $error("frames too close together");
endmodule

// ===== testbench/dss_tb_top.sv
// Bench joining host and converter ends, plus a hand-driven link.
module dac_serial_setup_commands_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {
    logic [23:0] word;
    logic [3:0] load;
    logic ref_on;
  } dss_row_s;

  logic ref_clk = 1'b0;
  logic rst_b;
  logic cmd_valid;
  logic cmd_ready;
  logic busy;
  logic h_done;
  logic d_done;
  logic d2_done;
  dss_pkg::dss_word_t cmd_word;
  logic [15:0] in_w [4];
  logic [15:0] out_w [4];
  logic [15:0] out2_w [4];
  logic [15:0] exp_w [4];
  logic [3:0] load;
  logic [3:0] load2;
  logic [3:0] exp_ld;
  logic ref_on;
  logic ref2;
  int errors;
  int d2_frames = 0;
  int cmp_count;
  // Some rows fill ignored fields with ones to show they have no effect.
  dss_row_s rows [6] = '{
    '{24'h30000A, 4'hA, 1'b0}, '{24'hF7FFF5, 4'h5, 1'b0},
    '{24'h380001, 4'h5, 1'b1}, '{24'h000003, 4'h5, 1'b1},
    '{24'hFFFFFE, 4'h5, 1'b0}, '{24'h30FFF0, 4'h0, 1'b0}};

  dss_if lk();
  dss_if lk2();

  // Clock of 100 ns period.
  always #50 ref_clk = ~ref_clk;

  // Counts frames that the second converter accepts, so a long frame
  // that executed twice would show up as an extra count.
  always @(posedge ref_clk) begin
    if (d2_done === 1'b1) d2_frames <= d2_frames + 1;
  end

  dss_host dss_host_i (.ref_clk(ref_clk), .rst_b(rst_b),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_word(cmd_word),
    .busy(busy), .frame_done(h_done), .link(lk.host));
  dss_device dss_device_i (.ref_clk(ref_clk), .rst_b(rst_b),
    .link(lk.dev), .chan_input_word(in_w), .chan_output_word(out_w),
    .output_load_control(load), .reference_enable(ref_on),
    .frame_done(d_done));
  dss_device dss_device_i2 (.ref_clk(ref_clk), .rst_b(rst_b),
    .link(lk2.dev), .chan_input_word(in_w), .chan_output_word(out2_w),
    .output_load_control(load2), .reference_enable(ref2),
    .frame_done(d2_done));
  dss_link_chk dss_link_chk_i (.ref_clk(ref_clk), .rst_b(rst_b),
    .frame_sel_n(lk.frame_sel_n), .sclk(lk.sclk), .sdin(lk.sdin));

  // ----
  // Tasks
  // ----
  task automatic stop_test();
    $display("errors=%0d comparisons=%0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk_bits(input string nm, input logic [3:0] e,
                          input logic [3:0] g);
    cmp_count++;
    if (g !== e) begin
      errors++;
      $display("MISMATCH %s exp=%h got=%h", nm, e, g);
    end
  endtask

  task automatic chk_word(input string nm, input logic [15:0] e,
                          input logic [15:0] g);
    cmp_count++;
    if (g !== e) begin
      errors++;
      $display("MISMATCH %s exp=%h got=%h", nm, e, g);
    end
  endtask

  // One request through the host; waits are bounded to catch a hang.
  task automatic send(input logic [23:0] w);
    int n;
    n = 0;
    while (cmd_ready !== 1'b1 && n < 400) begin
      @(negedge ref_clk);
      n++;
    end
    cmd_word = w;
    cmd_valid = 1'b1;
    @(negedge ref_clk);
    cmd_valid = 1'b0;
    while (d_done !== 1'b1 && n < 800) begin
      @(negedge ref_clk);
      n++;
    end
    chk_bits("host_busy", 4'h2, {2'h0, busy, cmd_ready});
    @(negedge ref_clk);
    chk_bits("done_width", 4'h0, {3'h0, d_done});
    while (h_done !== 1'b1 && n < 800) begin
      @(negedge ref_clk);
      n++;
    end
    chk_bits("host_idle", 4'h1, {2'h0, busy, cmd_ready});
    // A hang is counted here; the remaining steps are all bounded.
    if (n >= 800) begin
      errors++;
      $display("MISMATCH send_timeout exp=done got=none");
    end
  endtask

  // Hand-driven host: data moves one cycle after the fall, bytes split by pauses.
  task automatic drive(input logic [23:0] w, input int nf);
    lk2.frame_sel_n = 1'b0;
    for (int i = 0; i < nf; i++) begin
      if (i % 8 == 0) repeat (8) @(negedge ref_clk);
      lk2.sdin = (i < 24) ? w[23 - i] : ~lk2.sdin;
      repeat (3) @(negedge ref_clk);
      lk2.sclk = 1'b1;
      repeat (4) @(negedge ref_clk);
      lk2.sclk = 1'b0;
      // Data moves one cycle after the fall; moving it with the fall
      // would let the converter's synchroniser see the new bit.
      @(negedge ref_clk);
    end
    repeat (4) @(negedge ref_clk);
    lk2.frame_sel_n = 1'b1;
    lk2.sdin = ~lk2.sdin;
    repeat (12) @(negedge ref_clk);
  endtask

  // Main sequence: table rows, then reset and the hand-driven frames.
  initial begin
    errors = 0;
    cmp_count = 0;
    rst_b = 1'b0;
    cmd_valid = 1'b0;
    cmd_word = 24'h000000;
    exp_ld = 4'h0;
    lk2.frame_sel_n = 1'b1;
    lk2.sclk = 1'b0;
    lk2.sdin = 1'b0;
    for (int c = 0; c < 4; c++) begin
      in_w[c] = 16'h0000;
      exp_w[c] = 16'h0000;
    end
    repeat (20) @(negedge ref_clk);
    rst_b = 1'b1;
    foreach (rows[r]) begin
      for (int c = 0; c < 4; c++) begin
        in_w[c] = {4'(r), 4'(c), 8'hA5};
        if (exp_ld[c]) exp_w[c] = in_w[c];
      end
      exp_ld = rows[r].load;
      send(rows[r].word);
      chk_bits("load", exp_ld, load);
      chk_bits("ref", {3'h0, rows[r].ref_on}, {3'h0, ref_on});
      for (int c = 0; c < 4; c++) begin
        chk_word("chan_out", exp_w[c], out_w[c]);
      end
    end
    send(24'h30000F);
    chk_bits("load_pre", 4'hF, load);
    send(24'h380001);
    chk_bits("ref_pre", 4'h1, {3'h0, ref_on});
    rst_b = 1'b0;
    @(negedge ref_clk);
    chk_bits("load_rst", 4'h0, load);
    chk_bits("ref_rst", 4'h0, {3'h0, ref_on});
    chk_bits("host_rst", 4'h1, {2'h0, busy, cmd_ready});
    rst_b = 1'b1;
    drive(24'h380001, 24);
    chk_bits("ref_set", 4'h1, {3'h0, ref2});
    drive(24'h380000, 23);
    chk_bits("ref_abort", 4'h1, {3'h0, ref2});
    drive(24'h30000C, 26);
    chk_bits("load_long", 4'hC, load2);
    chk_bits("frames", 4'h2, 4'(d2_frames));
    drive(24'h000000, 24);
    chk_bits("frames_end", 4'h3, 4'(d2_frames));
    for (int c = 0; c < 4; c++) begin
      exp_w[c] = (c >= 2) ? in_w[c] : 16'h0000;
      chk_word("chan_out2", exp_w[c], out2_w[c]);
    end
    stop_test();
  end
endmodule
